// ==== verilog/rpis_pkg.sv ====
package rpis_pkg;

    // register offsets on the paged register port
    localparam logic [7:0] ADDR_PORT_SELECT   = 8'h4c;
    localparam logic [7:0] ADDR_CSI_STATE     = 8'h7a;
    localparam logic [7:0] ADDR_EVENT_EN_HIGH = 8'hd8;
    localparam logic [7:0] ADDR_EVENT_EN_LOW  = 8'hd9;
    localparam logic [7:0] ADDR_STATUS_HIGH   = 8'hda;
    localparam logic [7:0] ADDR_STATUS_LOW    = 8'hdb;
    localparam logic [7:0] ADDR_GPIO_STATUS   = 8'hdc;
    localparam logic [7:0] ADDR_GPIO_EDGE_EN  = 8'hdd;
    localparam logic [7:0] ADDR_SENSOR_RISE   = 8'hde;
    localparam logic [7:0] ADDR_SENSOR_FALL   = 8'hdf;
    // receive port state registers live in another block; only their reads are observed here
    localparam logic [7:0] ADDR_PORT_STATE1   = 8'h50;
    localparam logic [7:0] ADDR_PORT_STATE2   = 8'h51;

    // high status field positions
    localparam int HI_CRC  = 0;
    localparam int HI_SEQ  = 1;
    localparam int HI_ENC  = 2;
    localparam int HI_SENS = 3;
    localparam int HI_GPIO = 4;
    localparam int HI_W    = 5;
    localparam int HI_EN_W = 3;

    // low status field positions
    localparam int LO_LOCK = 0;
    localparam int LO_PASS = 1;
    localparam int LO_PAR  = 2;
    localparam int LO_CSI  = 3;
    localparam int LO_OVF  = 4;
    localparam int LO_CNT  = 5;
    localparam int LO_LEN  = 6;
    localparam int LO_W    = 7;

    // gpio status layout: latched flags above live levels
    localparam int GPIO_N       = 4;
    localparam int GPIO_FLAG_LO = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;

endpackage : rpis_pkg

// ==== verilog/rpis_sticky.sv ====
`timescale 1ns/1ps
module rpis_sticky #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flag_r
);

    logic [W-1:0] flag_nxt;

    // a set landing with its clearing read survives, so no event is lost
    assign flag_nxt = (flag_r & ~clr) | set;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : rpis_sticky

// ==== verilog/rpis_edge.sv ====
`timescale 1ns/1ps
module rpis_edge #(
    parameter int N = 4
) (
    input  wire logic           mclk,
    input  wire logic           resetn,
    input  wire logic [N-1:0]   level,
    input  wire logic [2*N-1:0] edge_en,
    output logic      [N-1:0]   cond,
    output logic                any_change
);

    logic [N-1:0] prev_r;
    logic         armed_r;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    // no edge is reported until one level sample is held, so reset never fakes an edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prev_r  <= '0;
            armed_r <= 1'b0;
        end else begin
            prev_r  <= level;
            armed_r <= 1'b1;
        end
    end

    assign rise = level & ~prev_r & {N{armed_r}};
    assign fall = ~level & prev_r & {N{armed_r}};

    always_comb begin
        for (int k = 0; k < N; k++) begin
            cond[k] = (rise[k] & edge_en[2*k]) | (fall[k] & edge_en[2*k+1]);
        end
    end

    assign any_change = |(rise | fall);

endmodule : rpis_edge

// ==== verilog/rpis_top.sv ====
`timescale 1ns/1ps
module rpis_top #(
    parameter int         NPORT       = 2,
    parameter logic [7:0] ADDR_STATE1 = rpis_pkg::ADDR_PORT_STATE1,
    parameter logic [7:0] ADDR_STATE2 = rpis_pkg::ADDR_PORT_STATE2
) (
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [7:0]                   reg_wdata,
    output logic      [7:0]                   reg_rdata,
    output logic                              reg_rvalid,
    output logic                              reg_hit,
    input  wire logic [NPORT-1:0]             lock_changed,
    input  wire logic [NPORT-1:0]             port_valid_changed,
    input  wire logic [NPORT-1:0]             link_parity_fault,
    input  wire logic [NPORT-1:0]             csi_receiver_fault,
    input  wire logic [NPORT-1:0]             receive_overflow,
    input  wire logic [NPORT-1:0]             line_count_changed,
    input  wire logic [NPORT-1:0]             line_length_changed,
    input  wire logic [NPORT-1:0]             control_crc_fault,
    input  wire logic [NPORT-1:0]             control_sequence_fault,
    input  wire logic [NPORT-1:0]             link_encoding_fault,
    input  wire logic [NPORT-1:0]             sensor_changed,
    input  wire logic [rpis_pkg::GPIO_N*NPORT-1:0] fc_gpio_level,
    output logic      [NPORT-1:0]             port_irq
);

    localparam int PSEL_W = (NPORT > 1) ? $clog2(NPORT) : 1;
    localparam int GN     = rpis_pkg::GPIO_N;

    if (NPORT < 1 || NPORT > 8) begin : g_check
        $error("rpis_top: NPORT must be 1 to 8");
    end

    // port select register
    logic [PSEL_W-1:0] psel_r;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            psel_r <= '0;
        end else if (reg_wr && reg_addr == rpis_pkg::ADDR_PORT_SELECT) begin
            psel_r <= reg_wdata[PSEL_W-1:0];
        end
    end

    // per-port views gathered for the read mux
    logic [rpis_pkg::HI_W-1:0]    hi_q      [NPORT];
    logic [rpis_pkg::LO_W-1:0]    lo_q      [NPORT];
    logic [GN-1:0]                gflag_q   [NPORT];
    logic [GN-1:0]                glevel    [NPORT];
    logic [rpis_pkg::HI_EN_W-1:0] en_hi_q   [NPORT];
    logic [rpis_pkg::LO_W-1:0]    en_lo_q   [NPORT];
    logic [2*GN-1:0]              gedge_q   [NPORT];

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic                         sel;
        logic                         rd_state1;
        logic                         rd_state2;
        logic                         rd_csi;
        logic                         rd_gpio;
        logic                         rd_rise;
        logic                         rd_fall;
        logic                         wr_en_hi;
        logic                         wr_en_lo;
        logic                         wr_edge;
        logic                         rise_seen_r;
        logic                         fall_seen_r;
        logic                         sens_clr;
        logic [rpis_pkg::HI_EN_W-1:0] en_hi_r;
        logic [rpis_pkg::LO_W-1:0]    en_lo_r;
        logic [2*GN-1:0]              edge_en_r;
        logic [GN-1:0]                gcond;
        logic                         gchange;
        logic [rpis_pkg::HI_W-1:0]    hi_set;
        logic [rpis_pkg::HI_W-1:0]    hi_clr;
        logic [rpis_pkg::LO_W-1:0]    lo_set;
        logic [rpis_pkg::LO_W-1:0]    lo_clr;
        logic [rpis_pkg::HI_W-1:0]    hi_r;
        logic [rpis_pkg::LO_W-1:0]    lo_r;
        logic [GN-1:0]                gflag_r;

        assign sel       = (psel_r == PSEL_W'(p));
        assign rd_state1 = reg_rd && sel && reg_addr == ADDR_STATE1;
        assign rd_state2 = reg_rd && sel && reg_addr == ADDR_STATE2;
        assign rd_csi    = reg_rd && sel && reg_addr == rpis_pkg::ADDR_CSI_STATE;
        assign rd_gpio   = reg_rd && sel && reg_addr == rpis_pkg::ADDR_GPIO_STATUS;
        assign rd_rise   = reg_rd && sel && reg_addr == rpis_pkg::ADDR_SENSOR_RISE;
        assign rd_fall   = reg_rd && sel && reg_addr == rpis_pkg::ADDR_SENSOR_FALL;
        assign wr_en_hi  = reg_wr && sel && reg_addr == rpis_pkg::ADDR_EVENT_EN_HIGH;
        assign wr_en_lo  = reg_wr && sel && reg_addr == rpis_pkg::ADDR_EVENT_EN_LOW;
        assign wr_edge   = reg_wr && sel && reg_addr == rpis_pkg::ADDR_GPIO_EDGE_EN;

        // enable registers for this port
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                en_hi_r   <= '0;
                en_lo_r   <= '0;
                edge_en_r <= '0;
            end else begin
                if (wr_en_hi) begin
                    en_hi_r <= reg_wdata[rpis_pkg::HI_EN_W-1:0];
                end
                if (wr_en_lo) begin
                    en_lo_r <= reg_wdata[rpis_pkg::LO_W-1:0];
                end
                if (wr_edge) begin
                    edge_en_r <= reg_wdata[2*GN-1:0];
                end
            end
        end

        // sensor flag needs both status reads, in either order
        assign sens_clr = (rd_rise || rise_seen_r) && (rd_fall || fall_seen_r);

        always_ff @(posedge mclk) begin
            if (!resetn) begin
                rise_seen_r <= 1'b0;
                fall_seen_r <= 1'b0;
            end else if (sens_clr || !hi_r[rpis_pkg::HI_SENS]) begin
                rise_seen_r <= 1'b0;
                fall_seen_r <= 1'b0;
            end else begin
                rise_seen_r <= rise_seen_r || rd_rise;
                fall_seen_r <= fall_seen_r || rd_fall;
            end
        end

        rpis_edge #(
            .N          (GN)
        ) u_edge (
            .mclk       (mclk),
            .resetn     (resetn),
            .level      (fc_gpio_level[p*GN +: GN]),
            .edge_en    (edge_en_r),
            .cond       (gcond),
            .any_change (gchange)
        );

        always_comb begin
            hi_set                    = '0;
            hi_clr                    = '0;
            hi_set[rpis_pkg::HI_GPIO] = gchange;
            hi_clr[rpis_pkg::HI_GPIO] = rd_gpio;
            hi_set[rpis_pkg::HI_SENS] = sensor_changed[p];
            hi_clr[rpis_pkg::HI_SENS] = sens_clr;
            hi_set[rpis_pkg::HI_ENC]  = link_encoding_fault[p];
            hi_clr[rpis_pkg::HI_ENC]  = rd_state2;
            hi_set[rpis_pkg::HI_SEQ]  = control_sequence_fault[p];
            hi_clr[rpis_pkg::HI_SEQ]  = rd_state1;
            hi_set[rpis_pkg::HI_CRC]  = control_crc_fault[p];
            hi_clr[rpis_pkg::HI_CRC]  = rd_state1;
        end

        always_comb begin
            lo_set                    = '0;
            lo_clr                    = '0;
            lo_set[rpis_pkg::LO_LEN]  = line_length_changed[p];
            lo_clr[rpis_pkg::LO_LEN]  = rd_state2;
            lo_set[rpis_pkg::LO_CNT]  = line_count_changed[p];
            lo_clr[rpis_pkg::LO_CNT]  = rd_state2;
            lo_set[rpis_pkg::LO_OVF]  = receive_overflow[p];
            lo_clr[rpis_pkg::LO_OVF]  = rd_state2;
            lo_set[rpis_pkg::LO_CSI]  = csi_receiver_fault[p];
            lo_clr[rpis_pkg::LO_CSI]  = rd_csi;
            lo_set[rpis_pkg::LO_PAR]  = link_parity_fault[p];
            lo_clr[rpis_pkg::LO_PAR]  = rd_state1;
            lo_set[rpis_pkg::LO_PASS] = port_valid_changed[p];
            lo_clr[rpis_pkg::LO_PASS] = rd_state1;
            lo_set[rpis_pkg::LO_LOCK] = lock_changed[p];
            lo_clr[rpis_pkg::LO_LOCK] = rd_state1;
        end

        // writes never reach these; only the reads above clear them
        rpis_sticky #(
            .W      (rpis_pkg::HI_W)
        ) u_hi (
            .mclk   (mclk),
            .resetn (resetn),
            .set    (hi_set),
            .clr    (hi_clr),
            .flag_r (hi_r)
        );

        rpis_sticky #(
            .W      (rpis_pkg::LO_W)
        ) u_lo (
            .mclk   (mclk),
            .resetn (resetn),
            .set    (lo_set),
            .clr    (lo_clr),
            .flag_r (lo_r)
        );

        rpis_sticky #(
            .W      (GN)
        ) u_gpio (
            .mclk   (mclk),
            .resetn (resetn),
            .set    (gcond),
            .clr    ({GN{rd_gpio}}),
            .flag_r (gflag_r)
        );

        // sensor and gpio events carry their own enables upstream, so they pass unmasked
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                port_irq[p] <= 1'b0;
            end else begin
                port_irq[p] <= |(hi_r[rpis_pkg::HI_EN_W-1:0] & en_hi_r)
                             | |(lo_r & en_lo_r)
                             | hi_r[rpis_pkg::HI_SENS]
                             | |gflag_r;
            end
        end

        assign hi_q[p]    = hi_r;
        assign lo_q[p]    = lo_r;
        assign gflag_q[p] = gflag_r;
        assign glevel[p]  = fc_gpio_level[p*GN +: GN];
        assign en_hi_q[p] = en_hi_r;
        assign en_lo_q[p] = en_lo_r;
        assign gedge_q[p] = edge_en_r;
    end

    // read mux; the status byte is taken in the same edge that clears it
    logic [7:0]        rd_nxt;
    logic              hit_nxt;
    logic [PSEL_W-1:0] idx;

    always_comb begin
        idx     = psel_r;
        rd_nxt  = rpis_pkg::RESET_BYTE;
        hit_nxt = 1'b1;
        if (int'(idx) >= NPORT) begin
            idx = '0;
        end
        unique case (reg_addr)
            rpis_pkg::ADDR_PORT_SELECT: begin
                rd_nxt[PSEL_W-1:0] = psel_r;
            end
            rpis_pkg::ADDR_STATUS_HIGH: begin
                rd_nxt[rpis_pkg::HI_W-1:0] = hi_q[idx];
            end
            rpis_pkg::ADDR_STATUS_LOW: begin
                rd_nxt[rpis_pkg::LO_W-1:0] = lo_q[idx];
            end
            rpis_pkg::ADDR_GPIO_STATUS: begin
                rd_nxt = {gflag_q[idx], glevel[idx]};
            end
            rpis_pkg::ADDR_EVENT_EN_HIGH: begin
                rd_nxt[rpis_pkg::HI_EN_W-1:0] = en_hi_q[idx];
            end
            rpis_pkg::ADDR_EVENT_EN_LOW: begin
                rd_nxt[rpis_pkg::LO_W-1:0] = en_lo_q[idx];
            end
            rpis_pkg::ADDR_GPIO_EDGE_EN: begin
                rd_nxt = gedge_q[idx];
            end
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reg_rdata  <= rpis_pkg::RESET_BYTE;
            reg_rvalid <= 1'b0;
            reg_hit    <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_nxt;
                reg_hit   <= hit_nxt;
            end
        end
    end

endmodule : rpis_top

// ==== testbench/rpis_top_chk.sv ====
`timescale 1ns/1ps
module rpis_top_chk #(
    parameter int NPORT = 2
) (
    input wire logic                   mclk,
    input wire logic                   resetn,
    input wire logic [7:0]             reg_addr,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_wdata,
    input wire logic [7:0]             reg_rdata,
    input wire logic                   reg_rvalid,
    input wire logic                   reg_hit,
    input wire logic [NPORT-1:0]       lock_changed,
    input wire logic [NPORT-1:0]       port_valid_changed,
    input wire logic [NPORT-1:0]       link_parity_fault,
    input wire logic [NPORT-1:0]       csi_receiver_fault,
    input wire logic [NPORT-1:0]       receive_overflow,
    input wire logic [NPORT-1:0]       line_count_changed,
    input wire logic [NPORT-1:0]       line_length_changed,
    input wire logic [NPORT-1:0]       control_crc_fault,
    input wire logic [NPORT-1:0]       control_sequence_fault,
    input wire logic [NPORT-1:0]       link_encoding_fault,
    input wire logic [NPORT-1:0]       sensor_changed,
    input wire logic [4*NPORT-1:0]     fc_gpio_level,
    input wire logic [NPORT-1:0]       port_irq
);
    localparam int PSEL_W = (NPORT > 1) ? $clog2(NPORT) : 1;

    // quiet_r counts edges since any event or gpio change; clear checks need a settled window
    logic [7:0]         quiet_r;
    logic [4*NPORT-1:0] lvl_r;
    logic [7:0]         sel_r;
    logic [3:0]         live_sel;
    logic               ev_any;

    assign ev_any = |{lock_changed, port_valid_changed, link_parity_fault, csi_receiver_fault, receive_overflow,
                      line_count_changed, line_length_changed, control_crc_fault, control_sequence_fault,
                      link_encoding_fault, sensor_changed} | (fc_gpio_level != lvl_r);
    assign live_sel = fc_gpio_level[sel_r*4 +: 4];

    always_ff @(posedge mclk) begin
        lvl_r <= fc_gpio_level;
        if (!resetn || ev_any) begin
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hff) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    // select keeps only its low index bits; indices at or above NPORT fall back to port 0
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sel_r <= 8'h00;
        end else if (reg_wr && reg_addr == rpis_pkg::ADDR_PORT_SELECT) begin
            sel_r <= (int'(reg_wdata[PSEL_W-1:0]) < NPORT) ? 8'(reg_wdata[PSEL_W-1:0]) : 8'h00;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_hi_reserved_zero: assert property (
        reg_rvalid && $past(reg_addr) == rpis_pkg::ADDR_STATUS_HIGH |-> reg_rdata[7:5] == 3'h0)
        else $error("high status reserved bits not zero");
    a_lo_reserved_zero: assert property (
        reg_rvalid && $past(reg_addr) == rpis_pkg::ADDR_STATUS_LOW |-> !reg_rdata[7])
        else $error("low status reserved bit not zero");
    a_gpio_live_level: assert property (
        reg_rvalid && $past(reg_addr) == rpis_pkg::ADDR_GPIO_STATUS |-> reg_rdata[3:0] == $past(live_sel))
        else $error("gpio live level mismatch");
    a_gpio_flag_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_GPIO_STATUS ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_GPIO_STATUS && quiet_r >= 8'h04 |=> reg_rdata[7:4] == 4'h0)
        else $error("gpio flags survive a read");
    a_gpio_hi_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_GPIO_STATUS ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_HIGH && quiet_r >= 8'h04 |=> !reg_rdata[4])
        else $error("high bit 4 survives gpio status read");
    a_write_ignored: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_HIGH ##1 !reg_rd && !reg_wr
        ##1 reg_wr && reg_addr == rpis_pkg::ADDR_STATUS_HIGH ##1 !reg_rd && !reg_wr
        ##1 reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_HIGH && quiet_r >= 8'h04 |=> reg_rdata == $past(reg_rdata, 4))
        else $error("write changed high status");
    a_state1_hi_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_PORT_STATE1 ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_HIGH && quiet_r >= 8'h04 |=> reg_rdata[1:0] == 2'h0)
        else $error("state one read left high bits set");
    a_state1_lo_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_PORT_STATE1 ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_LOW && quiet_r >= 8'h04 |=> reg_rdata[2:0] == 3'h0)
        else $error("state one read left low bits set");
    a_state2_lo_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_PORT_STATE2 ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_LOW && quiet_r >= 8'h04 |=> reg_rdata[6:4] == 3'h0)
        else $error("state two read left low bits set");
    a_csi_read_clear: assert property (
        reg_rd && reg_addr == rpis_pkg::ADDR_CSI_STATE ##1 !reg_wr ##1
        reg_rd && reg_addr == rpis_pkg::ADDR_STATUS_LOW && quiet_r >= 8'h04 |=> !reg_rdata[3])
        else $error("csi state read left low bit 3 set");
endmodule : rpis_top_chk

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb;
    localparam int NPORT = 2;
    logic             mclk = 1'b0;
    logic             resetn = 1'b0;
    logic [7:0]       reg_addr = 8'h00;
    logic             reg_wr = 1'b0;
    logic             reg_rd = 1'b0;
    logic [7:0]       reg_wdata = 8'h00;
    logic [7:0]       reg_rdata;
    logic             reg_rvalid;
    logic             reg_hit;
    logic [1:0]       port_irq;
    logic [1:0]       ev [0:10] = '{default: 2'b00};
    logic [7:0]       gpio = 8'ha0;
    logic [7:0]       sa;
    logic [7:0]       ca;
    logic [7:0]       wa;
    int               b;
    int               fail_count = 0;
    int               total_checks = 0;

    always #2.5 mclk = ~mclk;

    rpis_top #(.NPORT(NPORT)) i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
        .lock_changed(ev[0]), .port_valid_changed(ev[1]), .link_parity_fault(ev[2]), .csi_receiver_fault(ev[3]),
        .receive_overflow(ev[4]), .line_count_changed(ev[5]), .line_length_changed(ev[6]),
        .control_crc_fault(ev[7]), .control_sequence_fault(ev[8]), .link_encoding_fault(ev[9]),
        .sensor_changed(ev[10]), .fc_gpio_level(gpio), .port_irq(port_irq));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    // one idle cycle between accesses keeps every strobe a single pulse
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, d)
        `CHK(reg_hit, (a inside {8'h4c, [8'hd8:8'hdd]}))
    endtask : rd

    task automatic pulse(input int k, input int p);
        @(posedge mclk);
        ev[k][p] <= 1'b1;
        @(posedge mclk);
        ev[k][p] <= 1'b0;
    endtask : pulse

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        for (int p = 0; p < NPORT; p++) begin
            wr(8'h4c, 8'(p));
            rd(8'hda, 8'h00);
            rd(8'hdb, 8'h00);
            rd(8'hdc, {4'h0, gpio[p*4 +: 4]});
        end
        // each event but sensor_changed on port 1: wrong clearing read keeps it, right one clears it
        for (int k = 0; k < 10; k++) begin
            sa = (k < 7) ? 8'hdb : 8'hda;
            b = (k < 7) ? k : k - 7;
            ca = (k inside {0, 1, 2, 7, 8}) ? 8'h50 : ((k == 3) ? 8'h7a : 8'h51);
            wa = (ca == 8'h50) ? 8'h51 : 8'h50;
            pulse(k, 1);
            rd(sa, 8'h01 << b);
            wr(8'h4c, 8'h00);
            rd(sa, 8'h00);
            wr(8'h4c, 8'h01);
            rd(wa, 8'h00);
            rd(sa, 8'h01 << b);
            rd(ca, 8'h00);
            rd(sa, 8'h00);
        end
        fork
            pulse(0, 1);
            rd(8'h50, 8'h00);
        join
        rd(8'hdb, 8'h01);
        rd(8'h50, 8'h00);
        pulse(7, 1);
        rd(8'hda, 8'h01);
        wr(8'hda, 8'hff);
        rd(8'hda, 8'h01);
        wr(8'hdb, 8'hff);
        rd(8'hdb, 8'h00);
        wr(8'hdc, 8'hff);
        rd(8'hdc, 8'h0a);
        @(posedge mclk);
        for (int k = 0; k < 11; k++) ev[k][1] <= 1'b1;
        @(posedge mclk);
        for (int k = 0; k < 11; k++) ev[k][1] <= 1'b0;
        rd(8'hda, 8'h0f);
        `CHK(port_irq[1], 1'b1)
        rd(8'hdb, 8'h7f);
        rd(8'h50, 8'h00);
        rd(8'h51, 8'h00);
        rd(8'h7a, 8'h00);
        rd(8'hdb, 8'h00);
        rd(8'hda, 8'h08);
        rd(8'hde, 8'h00);
        rd(8'hda, 8'h08);
        rd(8'hdf, 8'h00);
        rd(8'hda, 8'h00);
        `CHK(port_irq[1], 1'b0)
        wr(8'h4c, 8'h00);
        wr(8'hd9, 8'h01);
        rd(8'hd9, 8'h01);
        rd(8'h4c, 8'h00);
        pulse(2, 0);
        repeat (3) @(posedge mclk);
        #1 `CHK(port_irq, 2'b00)
        pulse(0, 0);
        @(posedge mclk);
        #1 `CHK(port_irq, 2'b01)
        rd(8'h50, 8'h00);
        @(posedge mclk);
        #1 `CHK(port_irq, 2'b00)
        wr(8'hdd, 8'h01);
        rd(8'hdd, 8'h01);
        @(posedge mclk);
        gpio[0] <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(8'hda, 8'h10);
        rd(8'hdc, 8'h11);
        rd(8'hdc, 8'h01);
        rd(8'hda, 8'h00);
        @(posedge mclk);
        gpio[0] <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(8'hda, 8'h10);
        rd(8'hdc, 8'h00);
        rd(8'hda, 8'h00);
        // high enable bit 2 lets an encoding error through; the state two read drops it again
        wr(8'hd8, 8'h04);
        pulse(9, 0);
        @(posedge mclk);
        #1 `CHK(port_irq, 2'b01)
        rd(8'h51, 8'h00);
        @(posedge mclk);
        #1 `CHK(port_irq, 2'b00)
        rd(8'h00, 8'h00);
        give_verdict();
    end

    // whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        give_verdict();
    end
endmodule : tb

bind rpis_top rpis_top_chk #(.NPORT(NPORT)) i_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit), .lock_changed(lock_changed), .port_valid_changed(port_valid_changed),
    .link_parity_fault(link_parity_fault), .csi_receiver_fault(csi_receiver_fault),
    .receive_overflow(receive_overflow), .line_count_changed(line_count_changed),
    .line_length_changed(line_length_changed), .control_crc_fault(control_crc_fault),
    .control_sequence_fault(control_sequence_fault), .link_encoding_fault(link_encoding_fault),
    .sensor_changed(sensor_changed), .fc_gpio_level(fc_gpio_level), .port_irq(port_irq));
